// ---- qpd_ctrl.sv ----
// Purpose: serial/parallel control and fault reporting of a four-channel predriver
// Assumes: shift clock, chip select and sense inputs are asynchronous to ref_clk
// Notes: load_sense_in high means drain above the fault reference
`timescale 1ns/1ps
module qpd_ctrl
  import qpd_pkg::*;
#(
  parameter int unsigned MASK_CYC = qpd_pkg::FAULT_MASK_CYC,
  parameter int unsigned REFRESH_CYC = qpd_pkg::RETRY_REFRESH_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic [qpd_pkg::NUM_CHANNELS-1:0] parallel_channel_in,
  input wire logic [qpd_pkg::NUM_CHANNELS-1:0] load_sense_in,
  input wire logic battery_fault_in,
  input wire logic retry_mode,
  output logic [qpd_pkg::NUM_CHANNELS-1:0] fet_drive_out,
  output logic fault_flag_n,
  output logic fault_flag_oe
);
  import qpd_pkg::*;

  // ****************************************
  // input synchronisation
  // ****************************************
  logic [SYNC_WIDTH-1:0] sync_bus;
  logic sclk_s;
  logic cs_n_s;
  logic sin_s;
  logic bat_s;
  logic retry_s;
  logic [NUM_CHANNELS-1:0] par_s;
  logic [NUM_CHANNELS-1:0] sense_s;

  qpd_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .async_in({retry_mode, battery_fault_in, load_sense_in, parallel_channel_in,
               serial_in, ~spi_cs_n, spi_sclk}),
    .sync_out(sync_bus)
  );

  assign sclk_s = sync_bus[0];
  // select synced inverted: cleared stages read deselected, no false fall after reset
  assign cs_n_s = ~sync_bus[1];
  assign sin_s = sync_bus[2];
  assign par_s = sync_bus[6:3];
  assign sense_s = sync_bus[10:7];
  assign bat_s = sync_bus[11];
  assign retry_s = sync_bus[12];

  // ****************************************
  // serial port
  // ****************************************
  logic sclk_d;
  logic cs_n_d;
  logic [3:0] shift_reg;
  logic [3:0] ctrl_reg;
  logic next_sclk_d;
  logic next_cs_n_d;
  logic [3:0] next_shift_reg;
  logic [3:0] next_ctrl_reg;
  logic next_serial_out;
  logic next_serial_out_oe;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic [NUM_CHANNELS-1:0] chan_fault;

  assign cs_fall = cs_n_d & ~cs_n_s;
  assign cs_rise = ~cs_n_d & cs_n_s;
  assign sclk_rise = ~sclk_d & sclk_s;
  assign sclk_fall = sclk_d & ~sclk_s;

  always_comb begin
    next_sclk_d = sclk_s;
    next_cs_n_d = cs_n_s;
    next_shift_reg = shift_reg;
    next_ctrl_reg = ctrl_reg;
    next_serial_out = serial_out;
    next_serial_out_oe = serial_out_oe;
    if (cs_rise) begin
      // fewer than four clocks leave fault bits in control
      next_ctrl_reg = shift_reg;
      next_shift_reg = SHIFT_RESET;
      next_serial_out_oe = 1'b0;
      next_serial_out = 1'b0;
    end else if (cs_fall) begin
      next_shift_reg = chan_fault;
      next_serial_out = chan_fault[3];
      next_serial_out_oe = 1'b1;
    end else if (!cs_n_s) begin
      if (sclk_rise) begin
        next_shift_reg = {shift_reg[2:0], sin_s};
      end else if (sclk_fall) begin
        // msb is the next device's input when cascaded
        next_serial_out = shift_reg[3];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
      shift_reg <= SHIFT_RESET;
      ctrl_reg <= CTRL_RESET;
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      sclk_d <= next_sclk_d;
      cs_n_d <= next_cs_n_d;
      shift_reg <= next_shift_reg;
      ctrl_reg <= next_ctrl_reg;
      serial_out <= next_serial_out;
      serial_out_oe <= next_serial_out_oe;
    end
  end

  // ****************************************
  // retry pulse timebase
  // ****************************************
  logic [REFRESH_CNT_W-1:0] refresh_cnt;
  logic [REFRESH_CNT_W-1:0] next_refresh_cnt;
  logic retry_pulse;
  logic retry_pulse_end;

  assign retry_pulse = refresh_cnt < REFRESH_CNT_W'(RETRY_PULSE_CYC);
  assign retry_pulse_end = refresh_cnt == REFRESH_CNT_W'(RETRY_PULSE_CYC - 1);

  always_comb begin
    if (refresh_cnt == REFRESH_CNT_W'(REFRESH_CYC - 1)) begin
      next_refresh_cnt = '0;
    end else begin
      next_refresh_cnt = refresh_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      refresh_cnt <= '0;
    end else begin
      refresh_cnt <= next_refresh_cnt;
    end
  end

  // ****************************************
  // per-channel gate and load-fault logic
  // ****************************************
  logic [NUM_CHANNELS-1:0] chan_short;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
      logic gate;
      logic short_flt;
      logic [MASK_CNT_W-1:0] mask_cnt;
      logic [DG_CNT_W-1:0] dg_cnt;
      logic next_gate;
      logic next_short_flt;
      logic [MASK_CNT_W-1:0] next_mask_cnt;
      logic [DG_CNT_W-1:0] next_dg_cnt;
      logic req;
      logic masked;
      logic open_flt;

      assign req = ctrl_reg[ch] | par_s[ch];
      assign masked = mask_cnt != '0;
      // open load is a live condition, only meaningful once settled
      assign open_flt = ~gate & ~masked & ~sense_s[ch] & ~bat_s & ~short_flt;

      always_comb begin
        next_gate = req;
        next_short_flt = short_flt;
        next_dg_cnt = '0;
        next_mask_cnt = masked ? mask_cnt - 1'b1 : mask_cnt;
        if (bat_s) begin
          next_gate = 1'b0;
        end else if (short_flt) begin
          next_gate = retry_s & retry_pulse & req;
        end
        if (next_gate != gate) begin
          next_mask_cnt = MASK_CNT_W'(MASK_CYC);
        end
        // latch-off clears when the request drops; set below wins
        if (!req) begin
          next_short_flt = 1'b0;
        end else if (short_flt && retry_s && retry_pulse_end && !sense_s[ch]) begin
          next_short_flt = 1'b0;
        end
        if (gate && !short_flt && !masked && !bat_s && sense_s[ch]) begin
          if (dg_cnt == DG_CNT_W'(SHORT_DEGLITCH_CYC - 1)) begin
            next_short_flt = 1'b1;
          end else begin
            next_dg_cnt = dg_cnt + 1'b1;
          end
        end
      end

      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          gate <= 1'b0;
          short_flt <= 1'b0;
          mask_cnt <= '0;
          dg_cnt <= '0;
        end else begin
          gate <= next_gate;
          short_flt <= next_short_flt;
          mask_cnt <= next_mask_cnt;
          dg_cnt <= next_dg_cnt;
        end
      end

      assign fet_drive_out[ch] = gate;
      assign chan_short[ch] = short_flt;
      assign chan_fault[ch] = short_flt | open_flt;
    end
  endgenerate

  // ****************************************
  // fault flag
  // ****************************************
  logic flag_pending;
  logic next_flag_pending;
  logic any_fault;

  assign any_fault = bat_s | (|chan_fault) | (|chan_short);

  always_comb begin
    next_flag_pending = flag_pending;
    // a present fault always wins over the release
    if (any_fault) begin
      next_flag_pending = 1'b1;
    end else if (cs_fall) begin
      next_flag_pending = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_pending <= 1'b0;
    end else begin
      flag_pending <= next_flag_pending;
    end
  end

  // pin only ever pulls low, so devices can share one line
  assign fault_flag_n = 1'b0;
  assign fault_flag_oe = flag_pending;
endmodule

// ---- qpd_pkg.sv ----
// Purpose: shared constants of the quad predriver control block
// Assumes: ref_clk at 100 MHz
// Notes: times kept in ns, cycle counts derived from them
package qpd_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FAULT_MASK_TIME_NS = 60000;
  localparam int unsigned SHORT_DEGLITCH_TIME_NS = 3000;
  localparam int unsigned RETRY_REFRESH_TIME_NS = 10000000;
  localparam int unsigned RETRY_PULSE_TIME_NS = 6000;
  // least times round up, longest times round down
  localparam int unsigned FAULT_MASK_CYC =
    (FAULT_MASK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SHORT_DEGLITCH_CYC = SHORT_DEGLITCH_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned RETRY_REFRESH_CYC = RETRY_REFRESH_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned RETRY_PULSE_CYC = RETRY_PULSE_TIME_NS / CLK_PERIOD_NS;
  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int unsigned NUM_CHANNELS = 4;
  localparam int unsigned SYNC_WIDTH = 13;
  localparam int unsigned MASK_CNT_W = 13;
  localparam int unsigned DG_CNT_W = 9;
  localparam int unsigned REFRESH_CNT_W = 20;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [3:0] SHIFT_RESET = 4'h0;
endpackage

// ---- qpd_sync.sv ----
// Purpose: two-stage synchroniser for asynchronous pins
// Assumes: each bit is an independent level
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module qpd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ---- qpd_host.sv ----
// Purpose: host model driving the serial control lines
// Assumes: shift clock period 125 ns, idle low outside frames
// Notes: samples serial_out on shift clock rise
`timescale 1ns/1ps
module qpd_host (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic serial_in,
  input wire logic serial_out
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    serial_in = 1'b0;
  end
  // ****************
  // one frame, msb first
  // ****************
  task automatic frame(input logic [3:0] wr, output logic [3:0] rd);
    // step off the ref_clk edge so pins never race the synchronisers
    #1;
    spi_cs_n = 1'b0;
    #100;
    for (int k = 3; k >= 0; k--) begin
      serial_in = wr[k];
      #62.5 spi_sclk = 1'b1;
      rd[k] = serial_out;
      #62.5 spi_sclk = 1'b0;
    end
    #100 spi_cs_n = 1'b1;
    // junk on the data line between frames
    serial_in = ~serial_in;
    // select must stay high long enough to be seen between frames
    #200;
  endtask
endmodule

// ---- qpd_ctrl_assertions.sv ----
// Purpose: port checks of the predriver control block
// Assumes: pins held for several ref_clk cycles
// Notes: latencies include two-stage synchronisers
`timescale 1ns/1ps
module qpd_ctrl_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic [3:0] parallel_channel_in,
  input wire logic battery_fault_in,
  input wire logic [3:0] fet_drive_out,
  input wire logic fault_flag_n,
  input wire logic fault_flag_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  oe_on_a: assert property (!spi_cs_n [*5] |-> serial_out_oe)
    else $error("serial out not driven in frame");
  oe_off_a: assert property (spi_cs_n [*5] |-> !serial_out_oe)
    else $error("serial out driven outside frame");
  sout_hold_a: assert property ((spi_sclk && !spi_cs_n) [*5] |-> $stable(serial_out))
    else $error("serial out moved while clock high");
  sout_idle_a: assert property (!serial_out_oe [*2] |-> !serial_out)
    else $error("serial out not cleared");
  flag_pin_a: assert property (fault_flag_n == 1'b0)
    else $error("flag drive value not low");
  batt_off_a: assert property (battery_fault_in [*6] |-> fet_drive_out == 4'h0)
    else $error("gate on during battery fault");
  batt_flag_a: assert property (battery_fault_in [*6] |-> fault_flag_oe)
    else $error("battery fault not flagged");
  flag_keep_a: assert property (fault_flag_oe && spi_cs_n && $past(spi_cs_n, 5)
    |=> fault_flag_oe)
    else $error("flag released without select fall");
  all_on_a: assert property ((parallel_channel_in == 4'hF && !battery_fault_in
    && !fault_flag_oe) [*6] |-> fet_drive_out == 4'hF)
    else $error("parallel request not driving gates");
endmodule
bind qpd_ctrl qpd_ctrl_checker chk (.ref_clk(ref_clk), .reset_n(reset_n),
  .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .parallel_channel_in(parallel_channel_in),
  .battery_fault_in(battery_fault_in), .fet_drive_out(fet_drive_out),
  .fault_flag_n(fault_flag_n), .fault_flag_oe(fault_flag_oe));

// ---- tb.sv ----
// Purpose: self-checking bench of the predriver control block
// Assumes: short mask and retry period for run time
// Notes: drain sense is the inverse of the gate, inj forces faults
`timescale 1ns/1ps
module tb;
  import qpd_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic spi_sclk, spi_cs_n, serial_in, serial_out, serial_out_oe;
  logic [3:0] parallel_channel_in = 4'h0;
  logic [3:0] load_sense_in = 4'hF;
  logic [3:0] fet_drive_out, rd, w;
  logic [3:0] inj = 4'h0;
  logic battery_fault_in = 1'b0;
  logic retry_mode = 1'b0;
  logic fault_flag_n, fault_flag_oe;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  always #5 ref_clk = ~ref_clk;
  // shorted load keeps drain high, open load keeps it low
  always @(posedge ref_clk) load_sense_in <= ~fet_drive_out ^ inj;
  qpd_ctrl #(.MASK_CYC(20), .REFRESH_CYC(700)) uut (.ref_clk(ref_clk),
    .reset_n(reset_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .parallel_channel_in(parallel_channel_in), .load_sense_in(load_sense_in),
    .battery_fault_in(battery_fault_in), .retry_mode(retry_mode),
    .fet_drive_out(fet_drive_out), .fault_flag_n(fault_flag_n),
    .fault_flag_oe(fault_flag_oe));
  qpd_host host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .serial_in(serial_in),
    .serial_out(serial_out));
  task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****************
  // hang guard
  // ****************
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(93));
    wait_cyc(6);
    reset_n <= 1'b1;
    wait_cyc(40);
    host.frame(4'h0, rd);
    check("flag", {3'h0, fault_flag_oe}, 4'h0);
    for (int i = 0; i < 6; i++) begin
      w = 4'($urandom);
      @(posedge ref_clk) parallel_channel_in <= (i == 0) ? 4'hF : 4'($urandom);
      host.frame(w, rd);
      check("fault", rd, 4'h0);
      wait_cyc(40);
      check("gate", fet_drive_out, w | parallel_channel_in);
    end
    @(posedge ref_clk) parallel_channel_in <= 4'h0;
    host.frame(4'h0, rd);
    @(posedge ref_clk) inj <= 4'h4;
    wait_cyc(40);
    check("open flag", {3'h0, fault_flag_oe}, 4'h1);
    host.frame(4'h0, rd);
    check("open word", rd, 4'h4);
    @(posedge ref_clk) inj <= 4'h0;
    wait_cyc(40);
    host.frame(4'h2, rd);
    check("flag cleared", {3'h0, fault_flag_oe}, 4'h0);
    $display("test open and write done");
    @(posedge ref_clk) inj <= 4'h2;
    wait_cyc(400);
    check("short gate", fet_drive_out, 4'h0);
    check("short flag", {3'h0, fault_flag_oe}, 4'h1);
    host.frame(4'h2, rd);
    check("short word", rd, 4'h2);
    wait_cyc(40);
    check("latched", fet_drive_out, 4'h0);
    @(posedge ref_clk) inj <= 4'h0;
    host.frame(4'h0, rd);
    host.frame(4'h2, rd);
    wait_cyc(40);
    check("relit", fet_drive_out, 4'h2);
    host.frame(4'h2, rd);
    check("flag after clear", {3'h0, fault_flag_oe}, 4'h0);
    @(posedge ref_clk) begin
      retry_mode <= 1'b1;
      inj <= 4'h2;
    end
    wait_cyc(400);
    check("retry flag", {3'h0, fault_flag_oe}, 4'h1);
    @(posedge ref_clk) inj <= 4'h0;
    wait_cyc(1600);
    check("retry gate", fet_drive_out, 4'h2);
    $display("test short done");
    // open load on channel 2 must stay hidden while the battery fault lasts
    @(posedge ref_clk) begin
      battery_fault_in <= 1'b1;
      inj <= 4'h4;
    end
    wait_cyc(40);
    check("batt gate", fet_drive_out, 4'h0);
    host.frame(4'h2, rd);
    check("batt word", rd, 4'h0);
    @(posedge ref_clk) inj <= 4'h0;
    @(posedge ref_clk) battery_fault_in <= 1'b0;
    wait_cyc(40);
    host.frame(4'h2, rd);
    check("batt flag", {3'h0, fault_flag_oe}, 4'h0);
    check("batt gate back", fet_drive_out, 4'h2);
    $display("test battery done");
    @(posedge ref_clk) begin
      retry_mode <= 1'b0;
      parallel_channel_in <= 4'h8;
      inj <= 4'h8;
    end
    wait_cyc(400);
    check("par short", fet_drive_out, 4'h2);
    @(posedge ref_clk) begin
      parallel_channel_in <= 4'h0;
      inj <= 4'h0;
    end
    wait_cyc(40);
    @(posedge ref_clk) parallel_channel_in <= 4'h8;
    wait_cyc(40);
    check("par relit", fet_drive_out, 4'hA);
    $display("test parallel done");
    print_verdict();
  end
endmodule
